// ### stm_monitor_chk.sv
// Checker for the register port and enable outputs of the monitor control
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_monitor_chk (
    input wire clk,
    input wire rst_n,
    input wire [`STM_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire link_up,
    input wire adc_clk_out,
    input wire adc_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Decode of the writable words and of control writes
    wire rw_hit = reg_addr == `STM_ADDR_CONTROL || reg_addr == `STM_ADDR_OFFSET_GAIN ||
        reg_addr == `STM_ADDR_SELECT_DECIM || reg_addr == `STM_ADDR_BYPASS;
    wire ctl_wr = reg_wr && reg_addr == `STM_ADDR_CONTROL;
    sequence s_wr_rd;
        (reg_wr && rw_hit) ##1 !reg_wr ##1 (reg_rd && reg_addr == $past(reg_addr, 2));
    endsequence
    sequence s_on;
        (ctl_wr && reg_wdata[1:0] == 2'h0 && link_up) ##1 (!reg_wr && link_up) [*4];
    endsequence
    sequence s_off;
        (ctl_wr && reg_wdata[1:0] == 2'h0) ##1 (!reg_wr && !link_up) [*4];
    endsequence
    // Clear needs a few cycles to reach the registered result memory
    sequence s_hist;
        (ctl_wr && reg_wdata[6]) ##1 (!reg_wr) [*4] ##1 (reg_rd && reg_addr == `STM_ADDR_READBACK);
    endsequence
    ////////////////////////////////////////////////////////////////
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        reg_rd && !rw_hit && reg_addr != `STM_ADDR_READBACK |=> reg_rdata == 16'h0000;
    endproperty
    property p_wr_rd;
        s_wr_rd |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_rst_hold;
        ctl_wr && reg_wdata[0] |-> ##[1:3] (!adc_enable && !adc_clk_out);
    endproperty
    property p_force;
        ctl_wr && reg_wdata[1:0] == 2'h2 |-> ##[1:3] adc_enable;
    endproperty
    property p_link_on;
        s_on |=> adc_enable;
    endproperty
    property p_link_off;
        s_off |=> !adc_enable;
    endproperty
    property p_hist;
        s_hist |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
    a_rst_hold: assert property (p_rst_hold) else $error("monitor not held");
    a_force: assert property (p_force) else $error("forced start missing");
    a_link_on: assert property (p_link_on) else $error("link up not enabling");
    a_link_off: assert property (p_link_off) else $error("enabled without link");
    a_hist: assert property (p_hist) else $error("history not cleared");
endmodule // stm_monitor_chk

bind stm_monitor_ctrl stm_monitor_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_up(link_up), .adc_clk_out(adc_clk_out), .adc_enable(adc_enable));

// ### stm_monitor_ctrl.v
// Control logic of the supply-voltage and temperature monitor
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_monitor_ctrl (
    clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    link_up,
    adc_valid,
    adc_data,
    cal_phase,
    cal_offset,
    adc_clk_out,
    adc_enable,
    sensor_select,
    sensor_reset,
    decim_factor,
    dc_offset,
    sequencer_active
);
    input wire clk;
    input wire rst_n;
    input wire [`STM_ADDR_W-1:0] reg_addr;
    input wire [15:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [15:0] reg_rdata;
    input wire link_up;
    input wire adc_valid;
    input wire [15:0] adc_data;
    input wire [1:0] cal_phase;
    input wire [7:0] cal_offset;
    output reg adc_clk_out;
    output reg adc_enable;
    output reg [2:0] sensor_select;
    output reg sensor_reset;
    output reg [2:0] decim_factor;
    output reg [7:0] dc_offset;
    output reg sequencer_active;

    localparam ST_IDLE = 4'b0001;
    localparam ST_DISCARD = 4'b0010;
    localparam ST_AVERAGE = 4'b0100;
    localparam ST_LOG = 4'b1000;

    localparam [1:0] PH_NORMAL = 2'h0;
    localparam [1:0] PH_GAIN = 2'h1;
    localparam [1:0] PH_OFFSET = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers

    reg rst_s1_reg;
    reg rst_s2_reg;
    wire srst_n;
    reg link_s1_reg;
    reg link_s2_reg;
    reg vld_s1_reg;
    reg vld_s2_reg;
    reg vld_s3_reg;
    reg [15:0] dat_s1_reg;
    reg [15:0] dat_s2_reg;

    // Asynchronous assert, synchronous release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign srst_n = rst_s2_reg;

    // Link and ADC side come from the analog domain; two flops before use
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            link_s1_reg <= 1'b0;
            link_s2_reg <= 1'b0;
            vld_s1_reg <= 1'b0;
            vld_s2_reg <= 1'b0;
            vld_s3_reg <= 1'b0;
            dat_s1_reg <= 16'h0000;
            dat_s2_reg <= 16'h0000;
        end else begin
            link_s1_reg <= link_up;
            link_s2_reg <= link_s1_reg;
            vld_s1_reg <= adc_valid;
            vld_s2_reg <= vld_s1_reg;
            vld_s3_reg <= vld_s2_reg;
            dat_s1_reg <= adc_data;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    // Symbol strobe on rising valid; data held stable by the ADC around it
    wire sym_stb;
    assign sym_stb = vld_s2_reg & ~vld_s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    reg [15:0] ctl_reg;
    reg [15:0] og_reg;
    reg [15:0] sd_reg;
    reg [15:0] by_reg;

    // Software writes; plain storage, no self-clearing bits
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ctl_reg <= `STM_RST_CONTROL;
            og_reg <= `STM_RST_OFFSET_GAIN;
            sd_reg <= `STM_RST_SELECT_DECIM;
            by_reg <= `STM_RST_BYPASS;
        end else if (reg_wr) begin
            case (reg_addr)
                `STM_ADDR_CONTROL: ctl_reg <= reg_wdata;
                `STM_ADDR_OFFSET_GAIN: og_reg <= reg_wdata;
                `STM_ADDR_SELECT_DECIM: sd_reg <= reg_wdata;
                `STM_ADDR_BYPASS: by_reg <= reg_wdata;
                default: ctl_reg <= ctl_reg;
            endcase
        end
    end

    wire hist_clr;
    wire mon_rst;
    wire bypass;
    wire [2:0] rd_sel;
    wire [15:0] readback;
    assign hist_clr = ctl_reg[`STM_CTL_HIST_CLR];
    assign mon_rst = ctl_reg[`STM_CTL_RESET];
    assign bypass = by_reg[`STM_BY_BYPASS];
    assign rd_sel = sd_reg[`STM_SD_RDSEL_HI:`STM_SD_RDSEL_LO];

    // Read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `STM_ADDR_CONTROL: reg_rdata <= ctl_reg;
                `STM_ADDR_OFFSET_GAIN: reg_rdata <= og_reg;
                `STM_ADDR_SELECT_DECIM: reg_rdata <= sd_reg;
                `STM_ADDR_BYPASS: reg_rdata <= by_reg;
                `STM_ADDR_READBACK: reg_rdata <= readback;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sensor ADC clock divider

    reg [3:0] div_cnt_reg;
    reg [3:0] half_len;
    localparam [31:0] HALF_FAST = `STM_HALF_FAST, HALF_MID = `STM_HALF_FAST * 2, HALF_SLOW = `STM_HALF_FAST * 4;

    // Half period grows by doubling per code; codes 2 and 3 share the slowest
    always @* begin
        case (ctl_reg[`STM_CTL_DIV_HI:`STM_CTL_DIV_LO])
            `STM_DIV_CODE_FAST: half_len = HALF_FAST[3:0];
            `STM_DIV_CODE_MID: half_len = HALF_MID[3:0];
            default: half_len = HALF_SLOW[3:0];
        endcase
    end

    // Clock only toggles while the monitors are out of reset
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            div_cnt_reg <= 4'h0;
            adc_clk_out <= 1'b0;
        end else if (mon_rst) begin
            div_cnt_reg <= 4'h0;
            adc_clk_out <= 1'b0;
        end else if (div_cnt_reg >= half_len - 4'h1) begin
            div_cnt_reg <= 4'h0;
            adc_clk_out <= ~adc_clk_out;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sensor control outputs

    wire run_ok;
    // Forced start bypasses the link wait; manual reset overrides both
    assign run_ok = ~mon_rst & (ctl_reg[`STM_CTL_FORCE] | link_s2_reg);

    reg [2:0] seq_sensor_reg;

    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            adc_enable <= 1'b0;
            sensor_select <= 3'h0;
            sensor_reset <= 1'b1;
            decim_factor <= 3'h4;
            dc_offset <= 8'h00;
            sequencer_active <= 1'b0;
        end else begin
            adc_enable <= run_ok;
            sequencer_active <= run_ok & ~bypass;
            if (bypass) begin
                sensor_select <= sd_reg[`STM_SD_BSEL_HI:`STM_SD_BSEL_LO];
                sensor_reset <= mon_rst | ~sd_reg[`STM_SD_RELEASE];
            end else begin
                sensor_select <= seq_sensor_reg;
                sensor_reset <= ~run_ok;
            end
            case (cal_phase)
                PH_GAIN: decim_factor <= sd_reg[`STM_SD_DG_HI:`STM_SD_DG_LO];
                PH_OFFSET: decim_factor <= sd_reg[`STM_SD_DO_HI:`STM_SD_DO_LO];
                default: decim_factor <= sd_reg[`STM_SD_DN_HI:`STM_SD_DN_LO];
            endcase
            if (ctl_reg[`STM_CTL_OFS_SEL]) begin
                dc_offset <= og_reg[`STM_OG_OFS_HI:`STM_OG_OFS_LO];
            end else begin
                dc_offset <= cal_offset;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample path: discard, average, log

    reg [3:0] state_reg;
    reg [2:0] cnt_reg;
    reg [18:0] acc_reg;
    wire [15:0] avg_val;
    wire [2:0] discard_n;
    wire [2:0] average_n;
    wire seq_en;
    assign discard_n = ctl_reg[`STM_CTL_DISCARD] ? `STM_DISCARD_LONG : `STM_DISCARD_SHORT;
    assign average_n = ctl_reg[`STM_CTL_AVERAGE] ? `STM_AVG_LONG : `STM_AVG_SHORT;
    assign seq_en = bypass ? (run_ok & sd_reg[`STM_SD_RELEASE]) : run_ok;

    // Sum of at most five symbols fits nineteen bits, so the quotient always fits sixteen
    wire [18:0] avg_quo;
    assign avg_quo = acc_reg / {16'h0000, average_n};
    assign avg_val = avg_quo[15:0];

    // Dropping enable returns to idle so each new enable discards again
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            acc_reg <= 19'h00000;
            seq_sensor_reg <= 3'h0;
        end else if (!seq_en) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            acc_reg <= 19'h00000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_DISCARD;
                    cnt_reg <= 3'h0;
                end
                ST_DISCARD: begin
                    if (sym_stb) begin
                        if (cnt_reg == discard_n - 3'h1) begin
                            state_reg <= ST_AVERAGE;
                            cnt_reg <= 3'h0;
                            acc_reg <= 19'h00000;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                ST_AVERAGE: begin
                    if (sym_stb) begin
                        acc_reg <= acc_reg + {3'h0, dat_s2_reg};
                        if (cnt_reg == average_n - 3'h1) begin
                            state_reg <= ST_LOG;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                end
                ST_LOG: begin
                    // Outside bypass the sequencer steps to the next sensor; the discard restarts in both modes
                    state_reg <= ST_DISCARD;
                    cnt_reg <= 3'h0;
                    acc_reg <= 19'h00000;
                    if (!bypass) begin
                        seq_sensor_reg <= (seq_sensor_reg == `STM_SENSOR_TEMP) ? 3'h0 : seq_sensor_reg + 3'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    wire [2:0] log_addr;
    assign log_addr = bypass ? sd_reg[`STM_SD_BSEL_HI:`STM_SD_BSEL_LO] : seq_sensor_reg;

    // Result store; history clear wipes all logged samples while held
    stm_result_mem u_mem (
        .clk(clk),
        .rst_n(srst_n),
        .wr_en(state_reg == ST_LOG),
        .wr_addr(log_addr),
        .wr_data(avg_val),
        .clr(hist_clr),
        .rd_addr(rd_sel),
        .rd_data(readback)
    );
endmodule // stm_monitor_ctrl

// ### stm_monitor_ctrl_tb.sv
// Self-checking testbench of the monitor control
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_monitor_ctrl_tb;
    localparam [8:0] CTL = `STM_ADDR_CONTROL;
    localparam [8:0] OFS = `STM_ADDR_OFFSET_GAIN;
    localparam [8:0] SEL = `STM_ADDR_SELECT_DECIM;
    localparam [8:0] RBK = `STM_ADDR_READBACK;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [8:0] reg_addr = 9'h000;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg link_up = 1'b0;
    reg adc_valid = 1'b0;
    reg [15:0] adc_data = 16'h0000;
    reg [1:0] cal_phase = 2'h0;
    reg [7:0] cal_offset = 8'h00;
    wire [15:0] reg_rdata;
    wire adc_clk_out, adc_enable, sensor_reset, sequencer_active;
    wire [2:0] sensor_select, decim_factor;
    wire [7:0] dc_offset;
    integer errors = 0;
    integer comparisons = 0;
    integer seed = 32'hd1bd;
    integer k;
    reg rd_d = 1'b0;
    reg [15:0] q[$];
    reg [15:0] a0, a2, r;
    time t0;

    stm_monitor_ctrl DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
        .adc_valid(adc_valid), .adc_data(adc_data), .cal_phase(cal_phase), .cal_offset(cal_offset),
        .adc_clk_out(adc_clk_out), .adc_enable(adc_enable), .sensor_select(sensor_select),
        .sensor_reset(sensor_reset), .decim_factor(decim_factor), .dc_offset(dc_offset),
        .sequencer_active(sequencer_active));

    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task test_done;
        begin
            if (errors == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Strobes last one cycle; a cycle passes before the next request
    task wr(input [8:0] a, input [15:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [8:0] a, input [15:0] e);
        begin
            q.push_back(e);
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
        end
    endtask
    // Data is held well around each valid edge, since both pass synchronisers
    task smp(input integer sk, input integer na, output [15:0] av);
        reg [19:0] s;
        reg [15:0] d;
        integer i;
        begin
            s = 20'h00000;
            for (i = 0; i < sk + na; i = i + 1) begin
                d = $random(seed);
                if (i >= sk)
                    s = s + d;
                @(posedge clk) adc_data <= d;
                idle(3);
                adc_valid <= 1'b1;
                idle(4);
                adc_valid <= 1'b0;
            end
            idle(8);
            av = s / na;
        end
    endtask
    task per(input [15:0] e);
        begin
            idle(40);
            @(posedge adc_clk_out);
            t0 = $time;
            @(posedge adc_clk_out);
            chk(16'(($time - t0) / 20), e);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d)
            chk(reg_rdata, q.pop_front());
    end
    initial begin
        #400000;
        errors = errors + 1;
        test_done;
    end
    initial begin
        idle(4);
        rst_n <= 1'b1;
        idle(3);
        rd(CTL, `STM_RST_CONTROL);
        rd(OFS, `STM_RST_OFFSET_GAIN);
        rd(SEL, `STM_RST_SELECT_DECIM);
        rd(`STM_ADDR_BYPASS, 16'h0000);
        rd(9'h1E3, 16'h0000);
        chk(16'(adc_enable), 16'h0000);
        chk(16'(sensor_reset), 16'h0001);
        chk(16'(decim_factor), 16'h0004);
        r = $random(seed);
        wr(OFS, r);
        rd(OFS, r);
        wr(RBK, r);
        rd(RBK, 16'h0000);
        // Forced start, long discard, short average, sequencer running
        wr(CTL, 16'h0026);
        idle(4);
        chk(16'(adc_enable), 16'h0001);
        chk(16'(sequencer_active), 16'h0001);
        smp(6, 3, a0);
        chk(16'(sensor_select), 16'h0001);
        for (k = 0; k < 4; k = k + 1) begin
            wr(CTL, 16'h0022 | 16'(k << 2));
            per(k == 0 ? 16'h0004 : k == 1 ? 16'h0008 : 16'h0010);
        end
        r = $random(seed);
        cal_offset <= r[7:0];
        wr(OFS, {r[15:8], 8'h12});
        idle(3);
        chk(16'(dc_offset), 16'(r[7:0]));
        wr(CTL, 16'h8026);
        idle(3);
        chk(16'(dc_offset), 16'(r[15:8]));
        wr(SEL, 16'h0B98);
        for (k = 0; k < 3; k = k + 1) begin
            cal_phase <= k[1:0];
            idle(3);
            chk(16'(decim_factor), k == 0 ? 16'h0005 : k == 1 ? 16'h0006 : 16'h0003);
        end
        cal_phase <= 2'h0;
        // Held monitor, then bypass on sensor two with short discard, long average
        wr(CTL, 16'h0017);
        idle(3);
        chk(16'(adc_clk_out), 16'h0000);
        wr(`STM_ADDR_BYPASS, 16'h4000);
        wr(SEL, 16'hA002);
        wr(CTL, 16'h0016);
        idle(3);
        chk(16'(sensor_select), 16'h0002);
        chk(16'(sensor_reset), 16'h0000);
        chk(16'(sequencer_active), 16'h0000);
        smp(3, 5, a2);
        for (k = 0; k < 8; k = k + 1) begin
            wr(SEL, 16'h8002 | 16'(k << 12));
            idle(2);
            rd(RBK, k == 0 ? a0 : k == 2 ? a2 : 16'h0000);
        end
        wr(SEL, 16'h0002);
        idle(3);
        chk(16'(sensor_reset), 16'h0001);
        wr(SEL, 16'hA002);
        wr(CTL, 16'h0064);
        idle(3);
        rd(RBK, 16'h0000);
        rd(CTL, 16'h0064);
        chk(16'(adc_enable), 16'h0000);
        link_up <= 1'b1;
        idle(4);
        wr(CTL, 16'h0024);
        idle(4);
        chk(16'(adc_enable), 16'h0001);
        idle(4);
        test_done;
    end
endmodule // stm_monitor_ctrl_tb

// ### stm_regs.vh
// Register map, field positions, reset values and timing constants of the supply and temperature monitor
`ifndef STM_REGS_VH
`define STM_REGS_VH

// Register word indices (byte-free plain port addresses)
`define STM_ADDR_W 9
`define STM_ADDR_CONTROL 9'h1E2
`define STM_ADDR_OFFSET_GAIN 9'h1E7
`define STM_ADDR_SELECT_DECIM 9'h1E8
`define STM_ADDR_BYPASS 9'h1E9
`define STM_ADDR_READBACK 9'h1EA

// Reset values
`define STM_RST_CONTROL 16'h0025
`define STM_RST_OFFSET_GAIN 16'h0012
`define STM_RST_SELECT_DECIM 16'h0920
`define STM_RST_BYPASS 16'h0000

// Control word fields
`define STM_CTL_OFS_SEL 15
`define STM_CTL_HIST_CLR 6
`define STM_CTL_DISCARD 5
`define STM_CTL_AVERAGE 4
`define STM_CTL_DIV_HI 3
`define STM_CTL_DIV_LO 2
`define STM_CTL_FORCE 1
`define STM_CTL_RESET 0

// Offset/gain word fields
`define STM_OG_OFS_HI 15
`define STM_OG_OFS_LO 8

// Select/decimation word fields
`define STM_SD_RELEASE 15
`define STM_SD_RDSEL_HI 14
`define STM_SD_RDSEL_LO 12
`define STM_SD_DN_HI 11
`define STM_SD_DN_LO 9
`define STM_SD_DG_HI 8
`define STM_SD_DG_LO 6
`define STM_SD_DO_HI 5
`define STM_SD_DO_LO 3
`define STM_SD_BSEL_HI 2
`define STM_SD_BSEL_LO 0

// Bypass word field
`define STM_BY_BYPASS 14

// Sample counts
`define STM_DISCARD_SHORT 3'h3
`define STM_DISCARD_LONG 3'h6
`define STM_AVG_SHORT 3'h3
`define STM_AVG_LONG 3'h5

// Sensor codes
`define STM_NUM_SENSORS 5
`define STM_SENSOR_TEMP 3'h4

// ADC clock: system 50 MHz, half periods in system cycles for 12.5/6.25/3.125 MHz
`define STM_SYS_CLK_HZ 50000000
`define STM_ADC_HZ_FAST 12500000
`define STM_HALF_FAST ((`STM_SYS_CLK_HZ / `STM_ADC_HZ_FAST) / 2)
`define STM_DIV_CODE_FAST 2'h0
`define STM_DIV_CODE_MID 2'h1

`endif

// ### stm_result_mem.v
// Small register-output memory holding the logged result of each sensor
`timescale 1ns/100ps
`include "stm_regs.vh"
module stm_result_mem (
    clk,
    rst_n,
    wr_en,
    wr_addr,
    wr_data,
    clr,
    rd_addr,
    rd_data
);
    input wire clk;
    input wire rst_n;
    input wire wr_en;
    input wire [2:0] wr_addr;
    input wire [15:0] wr_data;
    input wire clr;
    input wire [2:0] rd_addr;
    output reg [15:0] rd_data;

    reg [15:0] mem_reg [0:`STM_NUM_SENSORS-1];
    integer i;

    // Writes and clear; clear wins since it wipes the whole history
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `STM_NUM_SENSORS; i = i + 1) begin
                mem_reg[i] <= 16'h0000;
            end
        end else if (clr) begin
            for (i = 0; i < `STM_NUM_SENSORS; i = i + 1) begin
                mem_reg[i] <= 16'h0000;
            end
        end else if (wr_en && (wr_addr < `STM_NUM_SENSORS)) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Registered read; reserved codes read as zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (rd_addr < `STM_NUM_SENSORS) begin
            rd_data <= mem_reg[rd_addr];
        end else begin
            rd_data <= 16'h0000;
        end
    end
endmodule // stm_result_mem
